// >>> hw/sld_drive.sv
// Segment display drive: registers, clock pick, phase sequencer, pin levels
`timescale 1ns/1ns
module sld_drive #(
	parameter int PHASE_BASE = 4,
	parameter int BLINK_BASE = 1
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Register port
	input  wire sld_pkg::sld_bus_t bus_in,
	output logic [7:0]            rd_data_out,
	// Display clock sources, asynchronous pins
	input  wire logic             crystal_clock_in,
	input  wire logic             internal_reference_clock_in,
	// Low power modes from the system
	input  wire logic             wait_mode_in,
	input  wire logic             stop_mode_in,
	// Glass pins
	output logic [63:0]           pin_level_out,
	output logic [63:0]           pin_enable_out,
	output logic [63:0]           pin_backplane_out,
	// Analog controls and status
	output sld_pkg::sld_bias_t    bias_out,
	output logic                  frame_irq_out,
	output logic [2:0]            phase_out,
	output logic                  running_out
);

	////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0]        supply;
		logic [7:0]        pmode;
		logic [7:0]        main;
		logic [7:0]        blink;
		logic [63:0]       pen;
		logic [63:0]       bpen;
		logic [63:0][7:0]  wf;
		logic [2:0]        xs;
		logic [2:0]        is;
		logic              xf;
		logic              rf;
		logic              dclk;
		sld_pkg::sld_disp_t st;
		logic [15:0]       div;
		logic [2:0]        phase;
		logic [11:0]       bcnt;
		logic              bphase;
		logic [63:0]       pins;
		logic [7:0]        rdata;
		logic              irq;
		sld_pkg::sld_bias_t bias;
	} sld_state_t;

	sld_state_t s_reg;
	sld_state_t s_next;
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	////////////////////////////////////////////////////////////////
	// Address falls in an eight-entry bank
	function automatic logic in_bank8(input logic [6:0] a, input logic [6:0] base);
		in_bank8 = (a[6:3] == base[6:3]);
	endfunction

	// Address falls in the waveform area
	function automatic logic in_wf(input logic [6:0] a);
		in_wf = (a[6] == sld_pkg::OFF_WF[6]);
	endfunction

	////////////////////////////////////////////////////////////////
	// Reset release through two flops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	////////////////////////////////////////////////////////////////
	logic              sel_clk;
	logic              tick;
	logic              disp_on;
	logic [2:0]        duty;
	logic [2:0]        pre;
	logic [2:0]        rate;
	logic [15:0]       div_lim;
	logic [11:0]       blink_lim;
	logic              frame_end;
	logic [2:0]        eff_phase;
	logic              blank_fp;
	logic [2:0]        widx;
	logic [5:0]        pidx;

	always_comb begin
		s_next = s_reg;
		s_next.rdata = sld_pkg::RST_BYTE;
		s_next.irq = 1'b0;
		widx = bus_in.addr[2:0];
		pidx = bus_in.addr[5:0];

		// Register writes, any field live at any time
		if (bus_in.wr) begin
			case (bus_in.addr)
				sld_pkg::OFF_SUPPLY: s_next.supply = bus_in.wdata;
				sld_pkg::OFF_PMODE:  s_next.pmode = bus_in.wdata;
				sld_pkg::OFF_MAIN:   s_next.main = bus_in.wdata;
				sld_pkg::OFF_BLINK:  s_next.blink = bus_in.wdata;
				default: begin
					if (in_bank8(bus_in.addr, sld_pkg::OFF_PEN)) begin
						s_next.pen[{widx, 3'h0} +: 8] = bus_in.wdata;
					end else if (in_bank8(bus_in.addr, sld_pkg::OFF_BPEN)) begin
						s_next.bpen[{widx, 3'h0} +: 8] = bus_in.wdata;
					end else if (in_wf(bus_in.addr)) begin
						s_next.wf[pidx] = bus_in.wdata;
					end
				end
			endcase
		end

		// Register reads, answered next cycle; unmapped reads zero
		if (bus_in.rd) begin
			case (bus_in.addr)
				sld_pkg::OFF_SUPPLY: s_next.rdata = s_reg.supply;
				sld_pkg::OFF_PMODE:  s_next.rdata = s_reg.pmode;
				sld_pkg::OFF_MAIN:   s_next.rdata = s_reg.main;
				sld_pkg::OFF_BLINK:  s_next.rdata = s_reg.blink;
				sld_pkg::OFF_STATUS: s_next.rdata = {3'h0, s_reg.bphase, s_reg.st, s_reg.phase};
				default: begin
					if (in_bank8(bus_in.addr, sld_pkg::OFF_PEN)) begin
						s_next.rdata = s_reg.pen[{widx, 3'h0} +: 8];
					end else if (in_bank8(bus_in.addr, sld_pkg::OFF_BPEN)) begin
						s_next.rdata = s_reg.bpen[{widx, 3'h0} +: 8];
					end else if (in_wf(bus_in.addr)) begin
						s_next.rdata = s_reg.wf[pidx];
					end
				end
			endcase
		end

		// Clock pins: three flops, a change counts once stages two and three agree
		s_next.xs = {s_reg.xs[1:0], crystal_clock_in};
		s_next.is = {s_reg.is[1:0], internal_reference_clock_in};
		if (s_reg.xs[1] == s_reg.xs[2]) begin
			s_next.xf = s_reg.xs[2];
		end
		if (s_reg.is[1] == s_reg.is[2]) begin
			s_next.rf = s_reg.is[2];
		end
		sel_clk = s_reg.main[sld_pkg::B_CLK_SEL] ? s_reg.rf : s_reg.xf;
		s_next.dclk = sel_clk;
		tick = sel_clk & ~s_reg.dclk;

		// Analog controls straight from the supply register
		s_next.bias.pump_on = s_reg.supply[sld_pkg::B_PUMP_SEL];
		s_next.bias.tripler = s_reg.supply[sld_pkg::B_REF_SEL];
		s_next.bias.pump_adj = s_reg.supply[sld_pkg::B_PADJ_HI:sld_pkg::B_PADJ_LO];
		s_next.bias.unbuffered = s_reg.supply[sld_pkg::B_BUF_SKIP];
		s_next.bias.bias_from_vdd =
			(s_reg.supply[sld_pkg::B_SRC_HI:sld_pkg::B_SRC_LO] == sld_pkg::SRC_FROM_VDD);
		s_next.bias.bias_external =
			(s_reg.supply[sld_pkg::B_SRC_HI:sld_pkg::B_SRC_LO] == sld_pkg::SRC_EXTERNAL);

		// Display runs only when on and not held off by a low power mode
		disp_on = s_reg.main[sld_pkg::B_ON]
			& ~(wait_mode_in & s_reg.pmode[sld_pkg::B_WAIT_DIS])
			& ~(stop_mode_in & s_reg.pmode[sld_pkg::B_STOP_DIS]);

		duty = s_reg.main[sld_pkg::B_DUTY_HI:sld_pkg::B_DUTY_LO];
		pre = s_reg.main[sld_pkg::B_PRE_HI:sld_pkg::B_PRE_LO];
		rate = s_reg.blink[sld_pkg::B_RATE_HI:sld_pkg::B_RATE_LO];
		div_lim = 16'(PHASE_BASE) << pre;
		blink_lim = 12'(BLINK_BASE) << rate;
		frame_end = 1'b0;

		case (s_reg.st)
			sld_pkg::ST_OFF: begin
				s_next.div = 16'h0000;
				s_next.phase = 3'h0;
				s_next.bcnt = 12'h000;
				s_next.bphase = 1'b0;
				if (disp_on) begin
					s_next.st = sld_pkg::ST_RUN;
				end
			end
			sld_pkg::ST_RUN: begin
				if (!disp_on) begin
					s_next.st = sld_pkg::ST_OFF;
				end else if (tick) begin
					if (s_reg.div >= div_lim - 16'h0001) begin
						s_next.div = 16'h0000;
						if (s_reg.phase >= duty) begin
							s_next.phase = 3'h0;
							frame_end = 1'b1;
						end else begin
							s_next.phase = s_reg.phase + 3'h1;
						end
					end else begin
						s_next.div = s_reg.div + 16'h0001;
					end
				end
				// Blink counted in frames, so its rate follows the frame rate
				if (!s_reg.blink[sld_pkg::B_BLINK]) begin
					s_next.bcnt = 12'h000;
					s_next.bphase = 1'b0;
				end else if (frame_end) begin
					if (s_reg.bcnt >= blink_lim - 12'h001) begin
						s_next.bcnt = 12'h000;
						s_next.bphase = ~s_reg.bphase;
					end else begin
						s_next.bcnt = s_reg.bcnt + 12'h001;
					end
				end
			end
			default: begin
				s_next.st = sld_pkg::ST_OFF;
			end
		endcase

		s_next.irq = frame_end & s_reg.pmode[sld_pkg::B_IRQ_EN];

		// Alternate plane only exists at quarter duty or less
		eff_phase = s_reg.phase;
		if ((s_reg.blink[sld_pkg::B_ALT]
			| (s_reg.bphase & s_reg.blink[sld_pkg::B_STYLE]))
			&& duty <= sld_pkg::DUTY_QUARTER) begin
			eff_phase = s_reg.phase + sld_pkg::ALT_SHIFT;
		end
		blank_fp = s_reg.blink[sld_pkg::B_BLANK]
			| (s_reg.bphase & ~s_reg.blink[sld_pkg::B_STYLE]);

		// Backplanes follow their own phase bits; frontplanes blank on request
		for (int i = 0; i < sld_pkg::NPINS; i++) begin
			if (s_reg.st != sld_pkg::ST_RUN || !s_reg.pen[i]) begin
				s_next.pins[i] = 1'b0;
			end else if (s_reg.bpen[i]) begin
				s_next.pins[i] = s_reg.wf[i][s_reg.phase];
			end else begin
				s_next.pins[i] = s_reg.wf[i][eff_phase] & ~blank_fp;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rd_data_out = s_reg.rdata;
	assign pin_level_out = s_reg.pins;
	assign pin_enable_out = s_reg.pen;
	assign pin_backplane_out = s_reg.pen & s_reg.bpen;
	assign bias_out = s_reg.bias;
	assign frame_irq_out = s_reg.irq;
	assign phase_out = s_reg.phase;
	assign running_out = (s_reg.st == sld_pkg::ST_RUN);

endmodule

// >>> hw/sld_pkg.sv
// Package of constants and types for the segment display drive block
// What this block does
// - Reference select bit: clear gives doubler, set gives tripler operation.
// - Buffer skip bit: clear keeps bias buffers, set selects unbuffered drive.
// - Supply source 01 derives the top bias level from the digital supply.
// - Frame interrupts are suppressed while the frame interrupt enable is clear.
// - Wait disable clear keeps display running in wait; set turns it off.
// - Stop disable set turns display off in stop; clear keeps it running.
// - Clock select set routes the internal reference clock to the display.
// - Three-bit prescaler divides the display clock, jointly with duty, into frames.
// - Three-bit duty field sets phase count: 011 quarter, 111 eighth duty.
// - Blink enable starts blinking when set, stops when clear, live writable.
// - Blink style: clear blanks the display, set switches to alternate plane at quarter duty or less.
// - Three-bit blink rate selects blink frequency; 100 about half a hertz.
// - Second plane and blank bits stay writable while running, effective at once.
// - Pin enable banks hold one independent enable bit per display pin.
// - Backplane enable bit turns an enabled pin into a backplane driver.
// - Each pin has an eight-bit waveform register; bit n means phase n.
// - Any backplane pin may be assigned to any phase, no fixed mapping.
// - Clock select clear routes the crystal clock to the display.
// - Supply source 10 takes display bias from the external supply pin.
package sld_pkg;

	////////////////////////////////////////////////////////////////
	localparam int AW = 7;
	localparam int NPINS = 64;
	localparam int NBANKS = 8;

	localparam logic [6:0] OFF_SUPPLY = 7'h00;
	localparam logic [6:0] OFF_PMODE  = 7'h01;
	localparam logic [6:0] OFF_MAIN   = 7'h02;
	localparam logic [6:0] OFF_BLINK  = 7'h03;
	localparam logic [6:0] OFF_STATUS = 7'h04;
	localparam logic [6:0] OFF_PEN    = 7'h08;
	localparam logic [6:0] OFF_BPEN   = 7'h10;
	localparam logic [6:0] OFF_WF     = 7'h40;

	localparam logic [7:0] RST_BYTE = 8'h00;

	////////////////////////////////////////////////////////////////
	// Supply register fields
	localparam int B_PUMP_SEL = 7;
	localparam int B_REF_SEL  = 6;
	localparam int B_PADJ_HI  = 5;
	localparam int B_PADJ_LO  = 4;
	localparam int B_BUF_SKIP = 2;
	localparam int B_SRC_HI   = 1;
	localparam int B_SRC_LO   = 0;
	localparam logic [1:0] SRC_FROM_VDD = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL = 2'h2;

	// Power mode register fields
	localparam int B_IRQ_EN   = 2;
	localparam int B_WAIT_DIS = 1;
	localparam int B_STOP_DIS = 0;

	// Main control fields
	localparam int B_ON       = 7;
	localparam int B_CLK_SEL  = 6;
	localparam int B_PRE_HI   = 5;
	localparam int B_PRE_LO   = 3;
	localparam int B_DUTY_HI  = 2;
	localparam int B_DUTY_LO  = 0;
	localparam logic [2:0] DUTY_QUARTER = 3'h3;
	localparam logic [2:0] DUTY_EIGHTH  = 3'h7;

	// Blink control fields
	localparam int B_BLINK    = 7;
	localparam int B_ALT      = 6;
	localparam int B_BLANK    = 5;
	localparam int B_STYLE    = 3;
	localparam int B_RATE_HI  = 2;
	localparam int B_RATE_LO  = 0;

	// Alternate plane sits four phases up
	localparam logic [2:0] ALT_SHIFT = 3'h4;

	////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [7:0]    wdata;
		logic          wr;
		logic          rd;
	} sld_bus_t;

	typedef struct packed {
		logic       pump_on;
		logic       tripler;
		logic [1:0] pump_adj;
		logic       unbuffered;
		logic       bias_from_vdd;
		logic       bias_external;
	} sld_bias_t;

	typedef enum logic [0:0] {
		ST_OFF = 1'b0,
		ST_RUN = 1'b1
	} sld_disp_t;

endpackage

// >>> verif/sld_glass_model.sv
// Far-side model: free-running display clock sources and glass segments
`timescale 1ns/1ns
module sld_glass_model #(
	parameter int XTAL_HALF = 40,
	parameter int REF_HALF  = 50
) (
	// Glass electrodes
	input  wire logic [63:0] pin_level_in,
	input  wire logic [63:0] pin_backplane_in,
	// Clock sources and lit segments
	output logic             crystal_clock_out,
	output logic             ref_clock_out,
	output logic [63:0]      lit_out
);
	// Oscillators run free; half periods put every toggle on a falling system clock edge, clear of the rising edges
	initial begin
		crystal_clock_out = 1'b0;
		forever #(XTAL_HALF) crystal_clock_out = ~crystal_clock_out;
	end
	initial begin
		ref_clock_out = 1'b0;
		forever #(REF_HALF) ref_clock_out = ~ref_clock_out;
	end
	assign lit_out = pin_level_in & ~pin_backplane_in;
endmodule

// >>> verif/sld_drive_checker.sv
// Assertion checker for the segment display drive
`timescale 1ns/1ns
module sld_drive_checker #(
	parameter int PHASE_BASE = 4,
	parameter int BLINK_BASE = 1
) (
	// Clock, reset, bus
	input wire logic              clk_in,
	input wire logic              rst_n_in,
	input wire sld_pkg::sld_bus_t bus_in,
	input wire logic [7:0]        rd_data_out,
	// Modes and outputs
	input wire logic              wait_mode_in,
	input wire logic              stop_mode_in,
	input wire logic [63:0]       pin_level_out,
	input wire logic [63:0]       pin_enable_out,
	input wire logic [63:0]       pin_backplane_out,
	input wire sld_pkg::sld_bias_t bias_out,
	input wire logic              frame_irq_out,
	input wire logic [2:0]        phase_out,
	input wire logic              running_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [2:0]  pm_reg;
	logic [3:0]  mc_reg;
	logic [63:0] pe_reg;
	logic [63:0] bp_reg;
	// Shadows follow writes with the same one-edge latency as the registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pm_reg <= 3'h0;
			mc_reg <= 4'h0;
		end else if (bus_in.wr && bus_in.addr == sld_pkg::OFF_PMODE) begin
			pm_reg <= bus_in.wdata[2:0];
		end else if (bus_in.wr && bus_in.addr == sld_pkg::OFF_MAIN) begin
			mc_reg <= {bus_in.wdata[7], bus_in.wdata[2:0]};
		end
	end
	// Pin bank shadows, so the pin enable and backplane outputs are held against what software wrote
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pe_reg <= 64'h0;
			bp_reg <= 64'h0;
		end else if (bus_in.wr && bus_in.addr[6:3] == sld_pkg::OFF_PEN[6:3]) begin
			pe_reg[{bus_in.addr[2:0], 3'h0} +: 8] <= bus_in.wdata;
		end else if (bus_in.wr && bus_in.addr[6:3] == sld_pkg::OFF_BPEN[6:3]) begin
			bp_reg[{bus_in.addr[2:0], 3'h0} +: 8] <= bus_in.wdata;
		end
	end
	sequence s_on_wr;
		bus_in.wr && bus_in.addr == sld_pkg::OFF_MAIN && bus_in.wdata[7] && !mc_reg[3] && !wait_mode_in
			&& !stop_mode_in;
	endsequence
	sequence s_sup_wr;
		bus_in.wr && bus_in.addr == sld_pkg::OFF_SUPPLY;
	endsequence
	property p_rd_idle; !bus_in.rd |=> rd_data_out == 8'h00; endproperty
	property p_bias; s_sup_wr |-> ##2 bias_out == {$past(bus_in.wdata[7:4], 2), $past(bus_in.wdata[2], 2),
		$past(bus_in.wdata[1:0], 2) == 2'h1, $past(bus_in.wdata[1:0], 2) == 2'h2}; endproperty
	// The pulse is launched from the enable as it stood one edge earlier
	property p_irq_gate; frame_irq_out |-> $past(pm_reg[2]); endproperty
	property p_irq_pulse; frame_irq_out |=> !frame_irq_out; endproperty
	property p_wait_off; wait_mode_in && pm_reg[1] |=> !running_out; endproperty
	property p_stop_off; stop_mode_in && pm_reg[0] |=> !running_out; endproperty
	property p_start; s_on_wr |=> !running_out ##1 running_out; endproperty
	property p_off_quiet; !running_out [*2] |-> phase_out == 3'h0 && pin_level_out == 64'h0; endproperty
	property p_phase_range; running_out |-> phase_out <= mc_reg[2:0]; endproperty
	property p_bp_enabled; (pin_backplane_out & ~pin_enable_out) == 64'h0 && pin_enable_out == pe_reg
		&& pin_backplane_out == (pe_reg & bp_reg); endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_bias: assert property (p_bias) else $error("bias controls wrong");
	a_irq_gate: assert property (p_irq_gate) else $error("frame irq while disabled");
	a_irq_pulse: assert property (p_irq_pulse) else $error("frame irq too long");
	a_wait_off: assert property (p_wait_off) else $error("running in wait");
	a_stop_off: assert property (p_stop_off) else $error("running in stop");
	a_start: assert property (p_start) else $error("start latency wrong");
	a_off_quiet: assert property (p_off_quiet) else $error("pins active while off");
	a_phase_range: assert property (p_phase_range) else $error("phase beyond duty");
	a_bp_enabled: assert property (p_bp_enabled) else $error("pin enables or backplanes wrong");
endmodule
bind sld_drive sld_drive_checker #(.PHASE_BASE(PHASE_BASE), .BLINK_BASE(BLINK_BASE)) sld_drive_checker_inst (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in), .rd_data_out(rd_data_out),
	.wait_mode_in(wait_mode_in), .stop_mode_in(stop_mode_in), .pin_level_out(pin_level_out),
	.pin_enable_out(pin_enable_out), .pin_backplane_out(pin_backplane_out), .bias_out(bias_out),
	.frame_irq_out(frame_irq_out), .phase_out(phase_out), .running_out(running_out));

// >>> verif/testbench.sv
// Self-checking bench for the segment display drive
`timescale 1ns/1ns
module testbench;
	logic clk_in, rst_n_in, xtal, refclk, wait_mode_in, stop_mode_in, frame_irq_out, running_out;
	sld_pkg::sld_bus_t bus_in;
	sld_pkg::sld_bias_t bias_out;
	logic [7:0] rd_data_out, rv, v;
	logic [63:0] pin_level_out, pin_enable_out, pin_backplane_out, lit;
	logic [2:0] phase_out;
	int failures, comparisons, n, k;
	logic [7:0] wf [4] = '{8'h04, 8'h01, 8'h08, 8'h02};
	logic [6:0] offs [8] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h08, 7'h10, 7'h40, 7'h20};
	logic [7:0] sup [3] = '{8'h81, 8'hC2, 8'h34};
	sld_drive #(.PHASE_BASE(1), .BLINK_BASE(1)) sld_drive_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.bus_in(bus_in), .rd_data_out(rd_data_out), .crystal_clock_in(xtal), .internal_reference_clock_in(refclk),
		.wait_mode_in(wait_mode_in), .stop_mode_in(stop_mode_in), .pin_level_out(pin_level_out),
		.pin_enable_out(pin_enable_out), .pin_backplane_out(pin_backplane_out), .bias_out(bias_out),
		.frame_irq_out(frame_irq_out), .phase_out(phase_out), .running_out(running_out));
	sld_glass_model sld_glass_model_inst (.pin_level_in(pin_level_out), .pin_backplane_in(pin_backplane_out),
		.crystal_clock_out(xtal), .ref_clock_out(refclk), .lit_out(lit));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		bus_in.wr <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a);
		@(posedge clk_in);
		bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		bus_in.rd <= 1'b0;
		#1 rv = rd_data_out;
	endtask
	// Enter phase p fresh, then let the pins catch up
	task automatic at_phase(input logic [2:0] p);
		n = 0;
		while ((phase_out === p) && n < 400) begin
			@(posedge clk_in);
			#1 n++;
		end
		while ((phase_out !== p) && n < 800) begin
			@(posedge clk_in);
			#1 n++;
		end
		repeat (2) @(posedge clk_in);
		#1 chk(n < 800, 1, "phase reached");
	endtask
	task automatic frame_chk(input logic second_plane_display, input logic blank);
		for (int p = 0; p < 4; p++) begin
			at_phase(p[2:0]);
			for (int i = 0; i < 4; i++) chk(pin_level_out[i], wf[i][p], "backplane level");
			chk(lit[8], v[p + (second_plane_display ? 4 : 0)] & ~blank, "segment level");
		end
	endtask
	task automatic frame_len(input int exp);
		n = 0;
		for (int j = 0; j < 2; j++) begin
			n = 0;
			do begin
				@(posedge clk_in);
				#1 n++;
			end while (frame_irq_out !== 1'b1 && n < 3000);
		end
		chk(n, exp, "frame length");
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial begin
		repeat (40000) @(posedge clk_in);
		failures++;
		finish_test();
	end
	initial begin
		{rst_n_in, wait_mode_in, stop_mode_in, failures, comparisons, bus_in} = '0;
		v = 8'h21;
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		wr(7'h20, 8'hA5);
		foreach (offs[i]) begin
			rd(offs[i]);
			chk(rv, 8'h00, "reset or unmapped value");
		end
		foreach (sup[i]) begin
			wr(sld_pkg::OFF_SUPPLY, sup[i]);
			rd(sld_pkg::OFF_SUPPLY);
			chk(rv, sup[i], "supply readback");
			chk(bias_out, {sup[i][7:4], sup[i][2], sup[i][1:0] == 2'h1, sup[i][1:0] == 2'h2}, "bias");
		end
		$display("Test done: registers");
		wr(sld_pkg::OFF_PMODE, 8'h05);
		wr(sld_pkg::OFF_MAIN, 8'h53);
		for (int i = 0; i < 4; i++) wr(sld_pkg::OFF_PEN + i[6:0], i < 3 ? 8'hFF : 8'h1F);
		wr(sld_pkg::OFF_BPEN, 8'h0F);
		for (int i = 0; i < 4; i++) wr(sld_pkg::OFF_WF + i[6:0], wf[i]);
		wr(sld_pkg::OFF_WF + 7'h08, v);
		wr(sld_pkg::OFF_MAIN, 8'hD3);
		chk(pin_enable_out, 64'h1FFF_FFFF, "pin enables");
		chk(pin_backplane_out, 64'h0F, "backplanes");
		frame_len(160);
		rd(sld_pkg::OFF_STATUS);
		chk(rv[3], 1'b1, "status running");
		chk(rv[2:0] <= 3'h3, 1'b1, "status phase");
		frame_chk(0, 0);
		wr(sld_pkg::OFF_BLINK, 8'h20);
		frame_chk(0, 1);
		wr(sld_pkg::OFF_BLINK, 8'h40);
		frame_chk(1, 0);
		wr(sld_pkg::OFF_BLINK, 8'h80);
		k = 0;
		repeat (4) begin
			at_phase(0);
			k += lit[8];
		end
		chk(k, 2, "blink frames");
		wr(sld_pkg::OFF_BLINK, 8'h89);
		for (int j = 0; j < 4; j++) begin
			at_phase(1);
			rv[j] = lit[8];
		end
		chk({rv[0] ^ rv[2], rv[1] ^ rv[3]}, 2'h3, "alternate blink rate");
		wr(sld_pkg::OFF_BLINK, 8'h00);
		k = 0;
		repeat (2) begin
			at_phase(0);
			k += lit[8];
		end
		chk(k, 2, "blink stopped");
		$display("Test done: display");
		wait_mode_in <= 1'b1;
		repeat (20) @(posedge clk_in);
		#1 chk(running_out, 1, "wait keeps display");
		stop_mode_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		#1 chk(running_out, 0, "stop turns off");
		{wait_mode_in, stop_mode_in} <= 2'b00;
		repeat (3) @(posedge clk_in);
		#1 chk(running_out, 1, "resume");
		wr(sld_pkg::OFF_PMODE, 8'h02);
		stop_mode_in <= 1'b1;
		n = 0;
		repeat (200) begin
			@(posedge clk_in);
			#1 n += frame_irq_out;
		end
		chk(n, 0, "frame irq suppressed");
		chk(running_out, 1, "stop keeps display");
		wait_mode_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		#1 chk(running_out, 0, "wait turns off");
		{wait_mode_in, stop_mode_in} <= 2'b00;
		wr(sld_pkg::OFF_PMODE, 8'h04);
		wr(sld_pkg::OFF_MAIN, 8'h0F);
		wr(sld_pkg::OFF_MAIN, 8'h8F);
		frame_len(128);
		$display("Test done: modes and clocks");
		finish_test();
	end
endmodule
